// file: logic/gpe_port.sv
// The register addresses and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module gpe_port (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // pins
    input  wire logic [7:0]  pinIn,
    output logic      [7:0]  pinOut,
    output logic      [7:0]  pinOe,
    output logic      [7:0]  pullUpEn,
    // alternate peripherals
    input  wire logic [7:0]  altEn,
    input  wire logic [7:0]  altOutEn,
    input  wire logic [7:0]  altOut,
    input  wire logic [7:0]  altOpenDrain,
    output logic      [7:0]  altIn,
    // interrupt request to the cpu
    input  wire logic        vectorFetch,
    output logic             extIrq
);
    // ==================================================
    // registers
    logic [7:0] pinDataLatch;
    logic [7:0] pinDirectionSelect;
    logic [7:0] pinModeOption;
    logic [1:0] extIrqSenseConfig;
    logic [7:0] syncA;
    logic [7:0] syncB;
    logic [7:0] prevPin;
    logic       reqLatch;
    logic       ack;
    logic       wrLow;
    logic [7:0] irqPins;
    logic [7:0] hit;
    logic [7:0] drvOut;
    logic [7:0] drvOe;
    logic [7:0] readLatch;

    // one wait cycle then acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end
    assign waitrequest = (read | write) & ~ack;
    assign wrLow = write & ack & byteenable[0];

    // software registers, one byte each
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinDataLatch       <= gpe_pkg::RST_LATCH;
            pinDirectionSelect <= gpe_pkg::RST_DIR;
            pinModeOption      <= gpe_pkg::RST_OPT;
        end else if (wrLow) begin
            case (address)
                gpe_pkg::ADDR_LATCH: pinDataLatch <= writedata[7:0];
                gpe_pkg::ADDR_DIR:   pinDirectionSelect <= writedata[7:0];
                gpe_pkg::ADDR_OPT:   pinModeOption <= writedata[7:0];
                default: ;
            endcase
        end
    end

    // sense configuration
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            extIrqSenseConfig <= gpe_pkg::RST_SENSE;
        end else if (wrLow && address == gpe_pkg::ADDR_SENSE) begin
            extIrqSenseConfig <= writedata[gpe_pkg::SENSE_LSB +: 2];
        end
    end

    // two-flop pin synchroniser and edge history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncA   <= 8'h00;
            syncB   <= 8'h00;
            prevPin <= 8'h00;
        end else begin
            syncA   <= pinIn;
            syncB   <= syncA;
            prevPin <= syncB;
        end
    end

    // pin drive with alternate override
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (altEn[i] && altOutEn[i]) begin
                drvOut[i] = altOut[i];
                drvOe[i]  = ~altOpenDrain[i] | ~altOut[i];
            end else if (pinDirectionSelect[i]) begin
                drvOut[i] = pinDataLatch[i];
                drvOe[i]  = pinModeOption[i] | ~pinDataLatch[i];
            end else begin
                drvOut[i] = 1'b0;
                drvOe[i]  = 1'b0;
            end
        end
    end

    // register-facing copies; data outputs from flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOut   <= 8'h00;
            pinOe    <= 8'h00;
            pullUpEn <= 8'h00;
            altIn    <= 8'h00;
        end else begin
            pinOut   <= drvOut;
            pinOe    <= drvOe;
            // pull-up only for pull-up input pins with no peripheral enabled
            pullUpEn <= ~pinDirectionSelect & pinModeOption & ~altEn;
            // output pins feed the peripheral from the latch
            altIn    <= (pinDirectionSelect & pinDataLatch)
                      | (~pinDirectionSelect & syncB);
        end
    end

    // edge detection on interrupt inputs
    always_comb begin
        irqPins = ~pinDirectionSelect & pinModeOption & ~altEn;
        case (extIrqSenseConfig)
            gpe_pkg::SENSE_RISE: hit = irqPins & syncB & ~prevPin;
            gpe_pkg::SENSE_FALL: hit = irqPins & ~syncB & prevPin;
            gpe_pkg::SENSE_BOTH: hit = irqPins & (syncB ^ prevPin);
            default:             hit = 8'h00;
        endcase
    end

    // hidden request latch; new event wins over clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reqLatch <= 1'b0;
        end else if (|hit) begin
            reqLatch <= 1'b1;
        end else if (vectorFetch) begin
            reqLatch <= 1'b0;
        end else if (wrLow && address == gpe_pkg::ADDR_SENSE
                     && writedata[1:0] != extIrqSenseConfig) begin
            reqLatch <= 1'b0;
        end
    end
    assign extIrq = reqLatch;

    // read data source per pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinDirectionSelect[i]) begin
                readLatch[i] = pinDataLatch[i];
            end else if (altEn[i] && altOutEn[i]) begin
                readLatch[i] = altOut[i];
            end else begin
                readLatch[i] = syncB[i];
            end
        end
    end

    // read data register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            case (address)
                gpe_pkg::ADDR_LATCH: readdata <= {24'h00_0000, readLatch};
                gpe_pkg::ADDR_DIR:
                    readdata <= {24'h00_0000, pinDirectionSelect};
                gpe_pkg::ADDR_OPT: readdata <= {24'h00_0000, pinModeOption};
                gpe_pkg::ADDR_SENSE:
                    readdata <= {30'h0000_0000, extIrqSenseConfig};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==================================================
    // assertions
    sequence s_rise;
        irqPins[0] && syncB[0] && !prevPin[0]
            && extIrqSenseConfig == gpe_pkg::SENSE_RISE;
    endsequence
    a_rise_sets_req: assert property (@(posedge clk) disable iff (rst)
        s_rise |=> extIrq) else $error("rising edge missed");
    a_fetch_clears: assert property (@(posedge clk) disable iff (rst)
        vectorFetch && !(|hit) |=> !extIrq)
        else $error("fetch did not clear");
    a_od_high_float: assert property (@(posedge clk) disable iff (rst)
        pinDirectionSelect[0] && !pinModeOption[0] && pinDataLatch[0]
        && !altEn[0] |=> !pinOe[0]) else $error("open drain drove");
    a_pp_drives: assert property (@(posedge clk) disable iff (rst)
        pinDirectionSelect[1] && pinModeOption[1] && !altEn[1]
        |=> pinOe[1] && pinOut[1] == $past(pinDataLatch[1]))
        else $error("push-pull wrong");
    a_input_no_drive: assert property (@(posedge clk) disable iff (rst)
        !pinDirectionSelect[2] && !altEn[2] |=> !pinOe[2])
        else $error("input pin driven");
    a_pullup_mode: assert property (@(posedge clk) disable iff (rst)
        pullUpEn[3] |-> $past(!pinDirectionSelect[3] && pinModeOption[3]))
        else $error("pull-up misplaced");
    a_sync_delay: assert property (@(posedge clk) disable iff (rst)
        syncB == $past(pinIn, 2)) else $error("sync depth wrong");
    a_alt_override: assert property (@(posedge clk) disable iff (rst)
        altEn[4] && altOutEn[4] |=> pinOut[4] == $past(altOut[4]))
        else $error("alternate not driving");
    a_bus_wait: assert property (@(posedge clk) disable iff (rst)
        (read || write) && !ack |=> ack) else $error("no bus answer");

    // ==================================================
    // request path, read-back, drive and sync assertions
    // an armed edge on any pin this cycle
    sequence s_any_hit;
        |hit;
    endsequence
    // a pending request with no fresh edge beside it
    sequence s_idle_pending;
        extIrq && !(|hit);
    endsequence
    // a differing sense write with no fetch beside it
    sequence s_sense_change;
        wrLow && address == gpe_pkg::ADDR_SENSE
            && writedata[1:0] != extIrqSenseConfig && !vectorFetch;
    endsequence
    // a latch read taken this cycle
    sequence s_latch_read;
        read && !ack && address == gpe_pkg::ADDR_LATCH;
    endsequence
    a_or_combine: assert property (@(posedge clk) disable iff (rst)
        s_any_hit |=> extIrq) else $error("combined edge missed");
    a_fall_sets_req: assert property (@(posedge clk) disable iff (rst)
        irqPins[0] && !syncB[0] && prevPin[0]
        && extIrqSenseConfig == gpe_pkg::SENSE_FALL |=> extIrq)
        else $error("falling edge missed");
    a_sense_clears: assert property (@(posedge clk) disable iff (rst)
        s_idle_pending ##0 s_sense_change |=> !extIrq)
        else $error("sense change kept request");
    a_hidden_hold: assert property (@(posedge clk) disable iff (rst)
        s_idle_pending ##0 (!vectorFetch
        && !(wrLow && address == gpe_pkg::ADDR_SENSE)) |=> extIrq)
        else $error("request lost");
    a_off_quiet: assert property (@(posedge clk) disable iff (rst)
        extIrqSenseConfig == gpe_pkg::RST_SENSE && !extIrq |=> !extIrq)
        else $error("request with sense off");
    a_irq_pin_only: assert property (@(posedge clk) disable iff (rst)
        !irqPins[1] |-> !hit[1]) else $error("edge on non-irq pin");
    a_alt_read: assert property (@(posedge clk) disable iff (rst)
        !pinDirectionSelect[5] && altEn[5] && altOutEn[5] && s_latch_read
        |=> readdata[5] == $past(altOut[5]))
        else $error("alternate output not read");
    a_out_read: assert property (@(posedge clk) disable iff (rst)
        pinDirectionSelect[6] && s_latch_read
        |=> readdata[6] == $past(pinDataLatch[6]))
        else $error("output read not latch");
    a_in_read: assert property (@(posedge clk) disable iff (rst)
        !pinDirectionSelect[7] && !(altEn[7] && altOutEn[7])
        && s_latch_read |=> readdata[7] == $past(syncB[7]))
        else $error("input read not pin");
    a_alt_od: assert property (@(posedge clk) disable iff (rst)
        altEn[4] && altOutEn[4] && altOpenDrain[4] && altOut[4]
        |=> !pinOe[4]) else $error("alternate open drain drove");
    a_alt_pp: assert property (@(posedge clk) disable iff (rst)
        altEn[3] && altOutEn[3] && !altOpenDrain[3] |=> pinOe[3])
        else $error("alternate push-pull idle");
    a_alt_in_latch: assert property (@(posedge clk) disable iff (rst)
        pinDirectionSelect[6] |=> altIn[6] == $past(pinDataLatch[6]))
        else $error("peripheral not fed latch");
    a_latch_write: assert property (@(posedge clk) disable iff (rst)
        wrLow && address == gpe_pkg::ADDR_LATCH
        |=> pinDataLatch == $past(writedata[7:0]))
        else $error("latch write lost");
    a_sync_first: assert property (@(posedge clk) disable iff (rst)
        syncA == $past(pinIn)) else $error("first sync stage wrong");
    a_pin_width: assert property (@(posedge clk) disable iff (rst)
        pinDirectionSelect[0] && pinModeOption[0] && !altEn[0]
        |=> pinOut[0] == $past(pinDataLatch[0]))
        else $error("pin zero not its own bit");
endmodule

// file: logic/gpe_pkg.sv
// Overview of operation
// - eight pins; bit x of latch, direction and option controls pin x
// - direction clear makes an input; latch reads return the sampled pin level
// - latch writes on an input pin store only, pin drive unchanged
// - direction set drives the latch; reads return the stored latch value
// - option selects floating or pull-up input; pull-up only in that mode
// - mode is {direction, option}: float, pull-up/irq, open-drain, push-pull
// - latch 0 drives low; latch 1 drives high or floats in open-drain
// - interrupt input pins raise a request on a matching programmed edge
// - sense field: 01 rising, 10 falling, 11 both edges
// - per-pin detections are ORed into one shared request
// - request latch is hidden and clears on vector fetch
// - changing the sense bits clears a pending request
// - an enabled peripheral removes pull-up and interrupt from its pin; it overrides direction and latch only when driving
// - a driving peripheral forces output, push-pull or open-drain as it asks
// - peripheral input pins stay readable through the latch register
// - input pin with enabled alternate output reads the alternate output
// - output pin with alternate input feeds the peripheral the driven level
package gpe_pkg;
    // ==================================================
    // register byte offsets, one 32-bit word apart
    localparam logic [3:0] ADDR_LATCH = 4'h0;
    localparam logic [3:0] ADDR_DIR   = 4'h4;
    localparam logic [3:0] ADDR_OPT   = 4'h8;
    localparam logic [3:0] ADDR_SENSE = 4'hC;
    // ==================================================
    // reset values
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR   = 8'h00;
    localparam logic [7:0] RST_OPT   = 8'h00;
    localparam logic [1:0] RST_SENSE = 2'h0;
    // ==================================================
    // sense field encodings
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;
    // sense field position in its register
    localparam int SENSE_LSB = 0;
endpackage

// file: sim/gpe_pads.sv
`timescale 1ns/1ps
// ==================================================
// pad ring and far-side drivers of the port
module gpe_pads (
    // clock
    input  wire logic       clk,
    // port side
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] pullUpEn,
    // far side
    input  wire logic [7:0] extVal,
    input  wire logic [7:0] extOe,
    output logic      [7:0] pinIn
);
    logic [7:0] noise = 8'h55;
    // floating pads with no pull-up wander every cycle
    always_ff @(posedge clk) noise <= ~noise;
    // port drive wins, far side backs off, else pull-up or noise
    always_comb
        for (int i = 0; i < 8; i++)
            pinIn[i] = pinOe[i] ? pinOut[i] : extOe[i] ? extVal[i] :
                       pullUpEn[i] ? 1'b1 : noise[i];
endmodule

// file: sim/tb_gpe_port.sv
`timescale 1ns/1ps
module tb_gpe_port;
    // ==================================================
    // signals
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [3:0]  byteenable = 4'h1;
    logic [31:0] readdata;
    logic        waitrequest, extIrq;
    logic [7:0]  pinIn, pinOut, pinOe, pullUpEn, altIn;
    logic [7:0]  altEn = 8'h00, altOutEn = 8'h00, altOut = 8'h00;
    logic [7:0]  altOpenDrain = 8'h00, extVal = 8'h00, extOe = 8'hFF;
    logic        vectorFetch = 1'b0;
    int          n_fail = 0, cmp_count = 0;
    logic [3:0]  ra [4] = '{4'h4, 4'h8, 4'hC, 4'h2};
    logic [7:0]  rw [4] = '{8'h0F, 8'hA5, 8'hFF, 8'hFF};
    logic [31:0] rq [4] = '{32'h0000_000F, 32'h0000_00A5, 32'h0000_0003,
                            32'h0000_0000};
    gpe_port u_gpe_port (.clk(clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .pullUpEn(pullUpEn), .altEn(altEn),
        .altOutEn(altOutEn), .altOut(altOut), .altOpenDrain(altOpenDrain),
        .altIn(altIn), .vectorFetch(vectorFetch), .extIrq(extIrq));
    gpe_pads u_gpe_pads (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
        .pullUpEn(pullUpEn), .extVal(extVal), .extOe(extOe), .pinIn(pinIn));
    // ==================================================
    // clock, checks and bus cycles
    initial forever #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= w;
        read <= !w;
        // hold until waitrequest is seen low at a rising edge
        @(posedge clk);
        while (waitrequest !== 1'b0)
            @(posedge clk);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog against a hung bus or sequence
    initial begin
        wt(5000);
        n_fail++;
        report_and_stop;
    end
    // ==================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(ra[i], rw[i]);
            rd(ra[i], rq[i]);
        end
        // reset in mid-run brings direction, option and sense back
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
            rd(ra[i], 32'h0000_0000);
        // latch first, then output mode
        wr(gpe_pkg::ADDR_LATCH, 8'h5A);
        wr(gpe_pkg::ADDR_OPT, 8'hFF);
        wr(gpe_pkg::ADDR_DIR, 8'hFF);
        wt(2);
        chk({pinOe, pinOut, pullUpEn}, 32'h00FF_5A00);
        rd(gpe_pkg::ADDR_LATCH, 32'h0000_005A);
        wr(gpe_pkg::ADDR_OPT, 8'h00);
        wt(2);
        chk(pinOe, 8'hA5);
        // input mode with far side driving
        extVal <= 8'h3C;
        wr(gpe_pkg::ADDR_DIR, 8'h00);
        wr(gpe_pkg::ADDR_OPT, 8'h0F);
        wr(gpe_pkg::ADDR_LATCH, 8'hFF);
        wt(4);
        chk({pinOe, pullUpEn}, 16'h000F);
        rd(gpe_pkg::ADDR_LATCH, 32'h0000_003C);
        // sense codes 01, 10 and 11 on pin 0
        for (int k = 1; k < 4; k++) begin
            wr(gpe_pkg::ADDR_SENSE, 8'(k));
            extVal[0] <= 1'b1;
            wt(6);
            chk(32'(extIrq), 32'(k & 1));
            vectorFetch <= 1'b1;
            @(posedge clk);
            vectorFetch <= 1'b0;
            wt(2);
            chk(32'(extIrq), 32'h0000_0000);
            extVal[0] <= 1'b0;
            wt(6);
            chk(32'(extIrq), 32'(k >> 1));
        end
        wr(gpe_pkg::ADDR_SENSE, 8'h01);
        wt(1);
        chk(32'(extIrq), 32'h0000_0000);
        // peripheral drives pin 7 while it is an input
        altEn <= 8'h80;
        altOutEn <= 8'h80;
        altOut <= 8'h80;
        wt(4);
        chk({pinOe[7], pinOut[7]}, 2'b11);
        rd(gpe_pkg::ADDR_LATCH, 32'h0000_00BC);
        // peripheral reads pin 6 while it is an output
        altEn <= 8'h40;
        altOutEn <= 8'h00;
        wr(gpe_pkg::ADDR_OPT, 8'hFF);
        wr(gpe_pkg::ADDR_DIR, 8'hFF);
        wr(gpe_pkg::ADDR_LATCH, 8'h40);
        wt(4);
        chk(32'(altIn[6]), 32'h0000_0001);
        wr(gpe_pkg::ADDR_LATCH, 8'h00);
        wt(4);
        chk(32'(altIn[6]), 32'h0000_0000);
        report_and_stop;
    end
endmodule
